// >>> src/irqc_ctrl.sv
// irqc_ctrl: interrupt request latching, masking, arbitration and entry sequence.
// assumes a core that reports instruction boundaries, pushes state and
// fetches the vector on request, and owns the global disable flag.
module irqc_ctrl
  import irqc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // special function register bus
  input wire logic [15:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // event sources
  input wire logic [3:0] ext_int_i,
  input wire logic counter_pin_zero_i,
  input wire logic counter_pin_one_i,
  input wire logic [N_PERIPH-1:0] periph_evt_i,
  input wire logic software_break_instruction_i,
  // processor core
  input wire logic instr_boundary_i,
  input wire logic iflag_i,
  input wire logic push_done_i,
  input wire logic fetch_done_i,
  output logic push_req_o,
  output logic set_iflag_o,
  output logic vec_fetch_o,
  output logic [15:0] vec_addr_o
);

  typedef struct packed {
    irqc_state_t state;
    logic [N_MASK-1:0] pend;
    logic [N_MASK-1:0] en;
    logic [7:0] edge_sel;
    logic brk_pend;
    logic [15:0] vec;
    logic iset;
    logic [7:0] rdata;
  } irqc_regs_t;

  irqc_regs_t r;
  irqc_regs_t next_r;

  logic [N_EXT-1:0] ext_pin;
  logic [N_EXT-1:0] ext_hit;
  logic [N_MASK-1:0] evt_set;
  logic [N_MASK-1:0] qual;
  logic [N_MASK-1:0] above_win;
  logic [3:0] win;
  logic accept;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  assign ext_pin = {counter_pin_one_i, counter_pin_zero_i, ext_int_i};

  genvar g;
  generate
    for (g = 0; g < N_EXT; g++)
    begin : g_edge
      irqc_edge_det u_edge (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(ext_pin[g]),
        .falling_i(r.edge_sel[g]),
        .hit_o(ext_hit[g])
      );
    end
  endgenerate

  // bit order follows priority: four pins, six peripherals, two counter pins, converter
  assign evt_set = {periph_evt_i[6], ext_hit[5:4], periph_evt_i[5:0], ext_hit[3:0]};

  assign qual = r.pend & r.en & {N_MASK{~iflag_i}};

  // lowest index wins
  always_comb
  begin
    win = 4'h0;
    for (int i = N_MASK - 1; i >= 0; i--)
    begin
      if (qual[i])
        win = 4'(i);
    end
  end

  assign above_win = (13'h0001 << win) - 13'h0001;
  // break needs no enable and ignores the disable flag
  assign accept = (r.state == ST_IDLE) && instr_boundary_i && ((|qual) || r.brk_pend);

  always_comb
  begin
    next_r = r;
    next_r.iset = 1'b0;
    if (sfr_wr_i)
    begin
      if (sfr_addr_i == ADDR_REQ1)
        next_r.pend[7:0] = r.pend[7:0] & sfr_wdata_i;
      else if (sfr_addr_i == ADDR_REQ2)
        next_r.pend[N_MASK-1:REQ2_LSB] = r.pend[N_MASK-1:REQ2_LSB] & sfr_wdata_i[REQ2_W-1:0];
      else if (sfr_addr_i == ADDR_EN1)
        next_r.en[7:0] = sfr_wdata_i;
      else if (sfr_addr_i == ADDR_EN2)
        next_r.en[N_MASK-1:REQ2_LSB] = sfr_wdata_i[REQ2_W-1:0];
      else if (sfr_addr_i == ADDR_EDGE)
        next_r.edge_sel = sfr_wdata_i;
    end
    if (sfr_rd_i)
    begin
      if (sfr_addr_i == ADDR_REQ1)
        next_r.rdata = r.pend[7:0];
      else if (sfr_addr_i == ADDR_REQ2)
        next_r.rdata = {3'h0, r.pend[N_MASK-1:REQ2_LSB]};
      else if (sfr_addr_i == ADDR_EN1)
        next_r.rdata = r.en[7:0];
      else if (sfr_addr_i == ADDR_EN2)
        next_r.rdata = {3'h0, r.en[N_MASK-1:REQ2_LSB]};
      else if (sfr_addr_i == ADDR_EDGE)
        next_r.rdata = r.edge_sel;
      else
        next_r.rdata = 8'h00;
    end
    case (r.state)
      ST_IDLE:
      begin
        if (accept)
        begin
          next_r.state = ST_PUSH;
          next_r.iset = 1'b1;
          if (|qual)
          begin
            next_r.pend[win] = 1'b0;
            next_r.vec = VEC_TOP - {10'h000, LVL_TAB[win], 1'b0};
          end
          else
          begin
            next_r.brk_pend = 1'b0;
            next_r.vec = VEC_BRK;
          end
        end
      end
      ST_PUSH:
      begin
        if (push_done_i)
          next_r.state = ST_FETCH;
      end
      ST_FETCH:
      begin
        if (fetch_done_i)
          next_r.state = ST_IDLE;
      end
      default:
      begin
        next_r.state = ST_IDLE;
      end
    endcase
    // a hardware event in the same cycle as a clear is kept
    next_r.pend = next_r.pend | evt_set;
    next_r.brk_pend = next_r.brk_pend | software_break_instruction_i;
  end

  // reset leaves through the reset vector fetch without a push
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r.state <= ST_FETCH;
      r.pend <= REQ_RST;
      r.en <= EN_RST;
      r.edge_sel <= EDGE_RST;
      r.brk_pend <= 1'b0;
      r.vec <= VEC_RESET;
      r.iset <= 1'b0;
      r.rdata <= 8'h00;
    end
    else
      r <= next_r;
  end

  assign push_req_o = (r.state == ST_PUSH);
  assign vec_fetch_o = (r.state == ST_FETCH);
  assign vec_addr_o = r.vec;
  assign set_iflag_o = r.iset;
  assign sfr_rdata_o = r.rdata;

  a_req_no_set:
  assert property (sfr_wr_i && sfr_addr_i == ADDR_REQ1 && evt_set[7:0] == 8'h00
    |=> (r.pend[7:0] & ~$past(r.pend[7:0])) == 8'h00)
    else $error("software write set a request bit");

  a_enable_write:
  assert property (sfr_wr_i && sfr_addr_i == ADDR_EN1 |=> r.en[7:0] == $past(sfr_wdata_i))
    else $error("enable register did not take written value");

  a_map_read:
  assert property (sfr_rd_i && sfr_addr_i == ADDR_EN2 && !sfr_wr_i
    |=> sfr_rdata_o == {3'h0, $past(r.en[N_MASK-1:REQ2_LSB])})
    else $error("second enable register read wrong");

  a_mask_gate:
  assert property (accept && !r.brk_pend |-> !iflag_i && (r.pend[win] && r.en[win]))
    else $error("masked source accepted");

  a_brk_unmasked:
  assert property (r.state == ST_IDLE && instr_boundary_i && r.brk_pend && qual == '0
    |=> r.state == ST_PUSH && vec_addr_o == VEC_BRK)
    else $error("break not taken");

  a_prio_order:
  assert property (accept && (|qual) |-> (qual & above_win) == '0 && qual[win])
    else $error("lower priority source granted");

  a_push_then_flag:
  assert property (accept |=> push_req_o && set_iflag_o ##1 !set_iflag_o)
    else $error("acceptance did not start push and set flag once");

  a_clear_served:
  assert property (accept && (|qual) && !evt_set[win] |=> !r.pend[$past(win)])
    else $error("serviced request not cleared");

  a_vector_load:
  assert property (push_req_o && push_done_i |=> vec_fetch_o && vec_addr_o == $past(vec_addr_o))
    else $error("vector fetch missing after push");

  a_edge_request:
  assert property (ext_hit[0] |=> r.pend[0])
    else $error("edge did not set request");

  a_boundary_only:
  assert property ($rose(push_req_o) |-> $past(instr_boundary_i))
    else $error("acceptance off an instruction boundary");

endmodule

// >>> src/irqc_pkg.sv
// irqc_pkg: shared constants and types of the interrupt request controller.
// assumes an 8-bit special function register bus with 16-bit addresses.
package irqc_pkg;

  // source counts
  localparam int N_MASK = 13;
  localparam int N_EXT = 6;
  localparam int N_PERIPH = 7;

  // special function space addresses
  localparam logic [15:0] ADDR_EDGE = 16'h003a;
  localparam logic [15:0] ADDR_REQ1 = 16'h003c;
  localparam logic [15:0] ADDR_REQ2 = 16'h003d;
  localparam logic [15:0] ADDR_EN1 = 16'h003e;
  localparam logic [15:0] ADDR_EN2 = 16'h003f;

  // reset values
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [12:0] REQ_RST = 13'h0000;
  localparam logic [12:0] EN_RST = 13'h0000;

  // field layout of the second request and enable registers
  localparam int REQ2_LSB = 8;
  localparam int REQ2_W = 5;

  // vectors: low byte of a level-n vector sits at VEC_TOP - 2n
  localparam logic [15:0] VEC_TOP = 16'hfffe;
  localparam logic [4:0] LVL_RESET = 5'h01;
  localparam logic [4:0] LVL_BRK = 5'h11;
  localparam logic [15:0] VEC_RESET = VEC_TOP - {10'h000, LVL_RESET, 1'b0};
  localparam logic [15:0] VEC_BRK = VEC_TOP - {10'h000, LVL_BRK, 1'b0};

  // priority level of each maskable source, index 0 is the most urgent
  localparam logic [4:0] LVL_TAB [0:12] = '{
    5'h02, 5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0a,
    5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10
  };

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PUSH = 3'b010,
    ST_FETCH = 3'b100
  } irqc_state_t;

endpackage

// >>> src/irqc_edge_det.sv
// irqc_edge_det: active-edge detector for one external interrupt pin.
// assumes the pin is already synchronous to clk_i.
module irqc_edge_det
  import irqc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pin and polarity
  input wire logic pin_i,
  input wire logic falling_i,
  // event
  output logic hit_o
);

  typedef struct packed {
    logic lvl;
  } irqc_edge_t;

  irqc_edge_t r;
  irqc_edge_t next_r;

  // the polarity is folded into the sampled level, so flipping the
  // polarity while the pin rests can itself look like an edge
  always_comb
  begin
    next_r.lvl = pin_i ^ falling_i;
  end

  assign hit_o = next_r.lvl & ~r.lvl;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= next_r;
  end

endmodule

// >>> sim/irqc_core_model.sv
// irqc_core_model: behavioural processor core beside the interrupt controller.
// assumes rising-edge updates, so bench inputs set at falling edges are settled;
// done pulses last one cycle; slow_i adds wait cycles.
module irqc_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bench control
  input wire logic bnd_en_i,
  input wire logic iflag_clr_i,
  input wire logic [3:0] slow_i,
  // controller side
  input wire logic push_req_i,
  input wire logic set_iflag_i,
  input wire logic vec_fetch_i,
  output logic instr_boundary_o,
  output logic iflag_o,
  output logic push_done_o,
  output logic fetch_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // no boundary during entry, so an entry is never nested
  assign instr_boundary_o = bnd_en_i && !push_req_i && !vec_fetch_i;
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      iflag_o <= 1'b0;
      push_done_o <= 1'b0;
      fetch_done_o <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else
    begin
      if (set_iflag_i)
        iflag_o <= 1'b1;
      else if (iflag_clr_i)
        iflag_o <= 1'b0;
      wait_cnt <= (push_done_o || fetch_done_o) ? 4'h0 : wait_cnt + 4'h1;
      push_done_o <= push_req_i && !push_done_o && wait_cnt >= slow_i;
      fetch_done_o <= vec_fetch_i && !fetch_done_o && wait_cnt >= slow_i;
    end
  end
endmodule

// >>> sim/interrupt_request_control_tb.sv
// interrupt_request_control_tb: self-checking bench for irqc_ctrl.
// assumes irqc_core_model as the core; inputs change on falling edges.
module interrupt_request_control_tb
  import irqc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, wr, rd_s, software_break_instruction, bnd_en, iclr, cntr0, cntr1, bnd, iflag;
  logic push_done, fetch_done, push_req, set_iflag, vec_fetch;
  logic [15:0] addr, vec_addr;
  logic [7:0] wdata, rdata;
  logic [3:0] ext_int, slow;
  logic [6:0] periph;
  int err_total, compares, cyc;
  irqc_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd_s), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .ext_int_i(ext_int),
    .counter_pin_zero_i(cntr0), .counter_pin_one_i(cntr1), .periph_evt_i(periph),
    .software_break_instruction_i(software_break_instruction), .instr_boundary_i(bnd), .iflag_i(iflag),
    .push_done_i(push_done), .fetch_done_i(fetch_done), .push_req_o(push_req),
    .set_iflag_o(set_iflag), .vec_fetch_o(vec_fetch), .vec_addr_o(vec_addr));
  irqc_core_model core (.clk_i(clk_i), .rst_n_i(rst_n_i), .bnd_en_i(bnd_en),
    .iflag_clr_i(iclr), .slow_i(slow), .push_req_i(push_req), .set_iflag_i(set_iflag),
    .vec_fetch_i(vec_fetch), .instr_boundary_o(bnd), .iflag_o(iflag),
    .push_done_o(push_done), .fetch_done_o(fetch_done));
  task automatic finish_test();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_i);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk_i);
    rd_s = 1'b0;
    chk(rdata, e);
  endtask
  // unmask clears the disable flag first; then waits for one whole entry
  task automatic svc(input logic [15:0] v, input logic unmask);
    int n;
    iclr = unmask;
    @(negedge clk_i);
    iclr = 1'b0;
    bnd_en = 1'b1;
    for (n = 0; n < 20 && push_req !== 1'b1; n++)
      @(negedge clk_i);
    bnd_en = 1'b0;
    chk(vec_addr, v);
    chk(set_iflag, 1'b1);
    for (n = 0; n < 20 && push_req !== 1'b0; n++)
      @(negedge clk_i);
    chk(vec_fetch, 1'b1);
    chk(vec_addr, v);
    for (n = 0; n < 20 && vec_fetch !== 1'b0; n++)
      @(negedge clk_i);
    chk(iflag, 1'b1);
  endtask
  task automatic t_sources();
    @(negedge clk_i);
    {ext_int, cntr0, cntr1, periph} = 13'h1fff;
    @(negedge clk_i);
    periph = 7'h00;
    rd_reg(ADDR_REQ1, 8'hff);
    rd_reg(ADDR_REQ2, 8'h1f);
    wr_reg(ADDR_REQ1, 8'h0f);
    rd_reg(ADDR_REQ1, 8'h0f);
    wr_reg(ADDR_REQ1, 8'hf0);
    wr_reg(ADDR_REQ1, 8'hff);
    rd_reg(ADDR_REQ1, 8'h00);
    {ext_int, cntr0, cntr1} = 6'h00;
    wr_reg(ADDR_REQ2, 8'h00);
    rd_reg(ADDR_REQ2, 8'h00);
    wr_reg(ADDR_EN1, 8'ha5);
    rd_reg(ADDR_EN1, 8'ha5);
    rd_reg(16'h003b, 8'h00);
    wr_reg(ADDR_EN2, 8'hff);
    rd_reg(ADDR_EN2, 8'h1f);
    $display("t_sources done");
  endtask
  task automatic t_accept();
    wr_reg(ADDR_EN1, 8'h00);
    wr_reg(ADDR_EDGE, 8'h0f);
    rd_reg(ADDR_EDGE, 8'h0f);
    rd_reg(ADDR_REQ1, 8'h0f);
    wr_reg(ADDR_REQ1, 8'h00);
    ext_int = 4'h8;
    periph = 7'h41;
    @(negedge clk_i);
    {ext_int, periph} = 11'h000;
    wr_reg(ADDR_EN1, 8'hff);
    repeat (3) @(negedge clk_i);
    chk(push_req, 1'b0);
    svc(16'hfff2, 1'b1);
    rd_reg(ADDR_REQ1, 8'h10);
    // disable flag still set from the entry: the pending timer request must wait
    bnd_en = 1'b1;
    @(negedge clk_i);
    bnd_en = 1'b0;
    chk(push_req, 1'b0);
    slow = 4'h3;
    svc(16'hffee, 1'b1);
    svc(16'hffde, 1'b1);
    software_break_instruction = 1'b1;
    @(negedge clk_i);
    software_break_instruction = 1'b0;
    svc(16'hffdc, 1'b0);
    $display("t_accept done");
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      finish_test();
    end
  end
  initial
  begin
    {rst_n_i, wr, rd_s, software_break_instruction, bnd_en, iclr, cntr0, cntr1} = 8'h00;
    {addr, wdata, ext_int, slow, periph} = 39'h0;
    repeat (8) @(negedge clk_i);
    chk(vec_addr, VEC_RESET);
    chk(vec_fetch, 1'b1);
    rst_n_i = 1'b1;
    rd_reg(ADDR_EN1, 8'h00);
    t_sources();
    t_accept();
    finish_test();
  end
endmodule
